/* File: hdl/cpci_pkg.sv */
// Package of constants and types for the core preamp control block.
package cpci_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the APB bus)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;   // Static control levels.
    localparam logic [7:0] TRIG_ADDR = 8'h04;   // Pulser trigger level.
    localparam logic [7:0] STAT_ADDR = 8'h08;   // Live status.
    localparam logic [7:0] IRQS_ADDR = 8'h0C;   // Sticky event bits.
    localparam logic [7:0] IRQM_ADDR = 8'h10;   // Interrupt mask.
    localparam logic [7:0] WID_ADDR = 8'h14;    // Last inhibit width.
    localparam logic [7:0] CNT_ADDR = 8'h18;    // Inhibit pulse count.

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_FRD_BIT = 0;    // Fast-reset disable.
    localparam int CTRL_PPE_BIT = 1;    // Pulser power enable.
    localparam int CTRL_SHP_BIT = 2;    // Pulser shape select.
    localparam int CTRL_GATE_BIT = 3;   // Gate acquisition on inhibit.
    localparam int IRQ_END_BIT = 0;     // Inhibit pulse ended.
    localparam int IRQ_OVF_BIT = 1;     // Width counter saturated.
    localparam int IRQ_START_BIT = 2;   // Inhibit pulse started.

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int CTRL_W = 4;
    localparam int IRQ_W = 3;
    localparam int WID_W = 24;
    localparam int CNT_W = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    localparam logic [WID_W-1:0] WID_MAX = 24'hFFFFFF;

    // Static control levels; all but gate_en are sent down the cable.
    typedef struct packed {
        logic gate_en;
        logic shape_sel;
        logic pulser_power_enable;
        logic core_fast_reset_disable;
    } cpci_ctrl_s;

    // Width measurement state.
    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_COUNT = 3'b010,
        MS_DONE = 3'b100
    } cpci_meas_e;

endpackage : cpci_pkg

/* File: hdl/cpci_sync.sv */
// Two-flip-flop synchroniser for one pin level.
`timescale 1ns/1ps

module cpci_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    // ------------------------------------------------------------
    // Two stages
    // ------------------------------------------------------------
    logic meta_q;   // First stage, read only by the second.

    // Both stages clear to low so the line reads idle after reset.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : cpci_sync

/* File: hdl/cpci_top.sv */
// Core preamp control cable logic: static levels, trigger, inhibit timing.
`timescale 1ns/1ps

module cpci_top
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Preamp cable
    output logic CORE_FAST_RESET_DISABLE,
    output logic PULSER_POWER_ENABLE,
    output logic PULSER_SHAPE_SEL,
    output logic PULSER_TRIGGER,
    input wire logic CORE_INHIBIT,
    // Acquisition side
    input wire logic EVENT_IN,
    output logic EVENT_ACCEPT,
    output logic ACQ_INHIBIT,
    // Interrupt
    output logic IRQ
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cpci_pkg::cpci_ctrl_s ctrl_q;       // Static control register.
    cpci_pkg::cpci_ctrl_s ctrl_d;
    logic trig_q;                       // Pulser trigger level.
    logic trig_d;
    logic [cpci_pkg::IRQ_W-1:0] irqs_q; // Sticky events.
    logic [cpci_pkg::IRQ_W-1:0] irqs_d;
    logic [cpci_pkg::IRQ_W-1:0] irqm_q; // Interrupt mask.
    logic [cpci_pkg::IRQ_W-1:0] irqm_d;
    logic [cpci_pkg::WID_W-1:0] wrun_q; // Running width count.
    logic [cpci_pkg::WID_W-1:0] wrun_d;
    logic [cpci_pkg::WID_W-1:0] wid_q;  // Last completed width.
    logic [cpci_pkg::WID_W-1:0] wid_d;
    logic [cpci_pkg::CNT_W-1:0] cnt_q;  // Completed pulse count.
    logic [cpci_pkg::CNT_W-1:0] cnt_d;
    cpci_pkg::cpci_meas_e ms_q;         // Measurement state.
    cpci_pkg::cpci_meas_e ms_d;
    logic [31:0] prdata_d;
    logic inh_s;                        // Synchronised inhibit.
    logic inh_prev_q;                   // Previous synchronised level.
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [cpci_pkg::IRQ_W-1:0] ev;     // Events this cycle.

    // ------------------------------------------------------------
    // Inhibit input synchroniser
    // ------------------------------------------------------------
    // The inhibit comes straight off the cable, so it is retimed first.
    cpci_sync u_inh_sync
    (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .async_in(CORE_INHIBIT),
        .sync_out(inh_s)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // The slave answers with zero wait states; PREADY is always high.
    assign PREADY = 1'b1;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PWRITE;
    always_comb
    begin
        case (PADDR)
            cpci_pkg::CTRL_ADDR,
            cpci_pkg::TRIG_ADDR,
            cpci_pkg::STAT_ADDR,
            cpci_pkg::IRQS_ADDR,
            cpci_pkg::IRQM_ADDR,
            cpci_pkg::WID_ADDR,
            cpci_pkg::CNT_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    // Unmapped addresses report an error in the access phase.
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    // ------------------------------------------------------------
    // Control and trigger registers
    // ------------------------------------------------------------
    // Levels change only on a write; nothing else touches them.
    always_comb
    begin
        ctrl_d = ctrl_q;
        trig_d = trig_q;
        if (wr_en && PADDR == cpci_pkg::CTRL_ADDR)
        begin
            ctrl_d = cpci_pkg::cpci_ctrl_s'(PWDATA[cpci_pkg::CTRL_W-1:0]);
        end
        if (wr_en && PADDR == cpci_pkg::TRIG_ADDR)
        begin
            trig_d = PWDATA[0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_q <= cpci_pkg::CTRL_RST;
            trig_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            trig_q <= trig_d;
        end
    end

    // Cable outputs come straight from flip-flops to stay glitch free.
    // Fast-reset disable level
    assign CORE_FAST_RESET_DISABLE = ctrl_q.core_fast_reset_disable;
    assign PULSER_POWER_ENABLE = ctrl_q.pulser_power_enable;
    assign PULSER_SHAPE_SEL = ctrl_q.shape_sel;
    assign PULSER_TRIGGER = trig_q;

    // ------------------------------------------------------------
    // Acquisition gating
    // ------------------------------------------------------------
    // The synchronised level lags the pin by two cycles; events within
    // that window of a reset edge may slip through.
    // Suppress during inhibit
    assign ACQ_INHIBIT = inh_s && ctrl_q.gate_en;
    assign EVENT_ACCEPT = EVENT_IN && !ACQ_INHIBIT;

    // ------------------------------------------------------------
    // Inhibit width measurement
    // ------------------------------------------------------------
    // Counted at the full 50 MHz clock, the fastest one available.
    always_comb
    begin
        ms_d = ms_q;
        wrun_d = wrun_q;
        wid_d = wid_q;
        cnt_d = cnt_q;
        ev = '0;
        case (ms_q)
            cpci_pkg::MS_IDLE:
            begin
                // Rising edge of the inhibit starts a new count.
                if (inh_s && !inh_prev_q)
                begin
                    ms_d = cpci_pkg::MS_COUNT;
                    wrun_d = cpci_pkg::WID_W'(1);
                    ev[cpci_pkg::IRQ_START_BIT] = 1'b1;
                end
            end
            cpci_pkg::MS_COUNT:
            begin
                if (inh_s)
                begin
                    // Saturate rather than wrap so a huge pulse is visible.
                    if (wrun_q != cpci_pkg::WID_MAX)
                    begin
                        wrun_d = wrun_q + cpci_pkg::WID_W'(1);
                    end
                    else if (!irqs_q[cpci_pkg::IRQ_OVF_BIT])
                    begin
                        ev[cpci_pkg::IRQ_OVF_BIT] = 1'b1;
                    end
                end
                else
                begin
                    ms_d = cpci_pkg::MS_DONE;
                end
            end
            cpci_pkg::MS_DONE:
            begin
                // Latch the result and report the end of the pulse.
                wid_d = wrun_q;
                cnt_d = cnt_q + cpci_pkg::CNT_W'(1);
                ev[cpci_pkg::IRQ_END_BIT] = 1'b1;
                ms_d = cpci_pkg::MS_IDLE;
            end
            default:
            begin
                ms_d = cpci_pkg::MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ms_q <= cpci_pkg::MS_IDLE;
            wrun_q <= '0;
            wid_q <= '0;
            cnt_q <= '0;
            inh_prev_q <= 1'b0;
        end
        else
        begin
            ms_q <= ms_d;
            wrun_q <= wrun_d;
            wid_q <= wid_d;
            cnt_q <= cnt_d;
            inh_prev_q <= inh_s;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Write one to clear; a new event in the same cycle wins the race.
    always_comb
    begin
        irqs_d = irqs_q;
        irqm_d = irqm_q;
        if (wr_en && PADDR == cpci_pkg::IRQS_ADDR)
        begin
            irqs_d = irqs_q & ~PWDATA[cpci_pkg::IRQ_W-1:0];
        end
        if (wr_en && PADDR == cpci_pkg::IRQM_ADDR)
        begin
            irqm_d = PWDATA[cpci_pkg::IRQ_W-1:0];
        end
        irqs_d = irqs_d | ev;
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            irqs_q <= cpci_pkg::IRQ_RST;
            irqm_q <= cpci_pkg::IRQ_RST;
        end
        else
        begin
            irqs_q <= irqs_d;
            irqm_q <= irqm_d;
        end
    end

    // Level interrupt while any unmasked sticky bit is set.
    assign IRQ = |(irqs_q & irqm_q);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data is registered in the setup cycle for the access phase.
    always_comb
    begin
        prdata_d = PRDATA;
        if (rd_en && !PENABLE)
        begin
            case (PADDR)
                cpci_pkg::CTRL_ADDR: prdata_d = {28'h0000000, ctrl_q};
                cpci_pkg::TRIG_ADDR: prdata_d = {31'h0, trig_q};
                cpci_pkg::STAT_ADDR:
                    prdata_d = {29'h0, ACQ_INHIBIT,
                                (ms_q == cpci_pkg::MS_COUNT), inh_s};
                cpci_pkg::IRQS_ADDR: prdata_d = {29'h0, irqs_q};
                cpci_pkg::IRQM_ADDR: prdata_d = {29'h0, irqm_q};
                cpci_pkg::WID_ADDR: prdata_d = {8'h00, wid_q};
                cpci_pkg::CNT_ADDR: prdata_d = {16'h0000, cnt_q};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PRDATA <= prdata_d;
        end
    end

endmodule : cpci_top

/* File: bench/cpci_monitor.sv */
// Assertion checker for the core preamp control block.
`timescale 1ns/1ps

module cpci_monitor
(
    // Clock, reset and bus
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Cable and acquisition
    input wire logic CORE_FAST_RESET_DISABLE,
    input wire logic PULSER_POWER_ENABLE,
    input wire logic PULSER_SHAPE_SEL,
    input wire logic PULSER_TRIGGER,
    input wire logic CORE_INHIBIT,
    input wire logic EVENT_IN,
    input wire logic EVENT_ACCEPT,
    input wire logic ACQ_INHIBIT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    logic wr_ctrl; // Completed write to the control levels.
    logic wr_trig; // Completed write to the trigger level.
    logic [2:0] lv; // The three static cable levels.
    assign wr_ctrl = PSEL & PENABLE & PWRITE & (PADDR == cpci_pkg::CTRL_ADDR);
    assign wr_trig = PSEL & PENABLE & PWRITE & (PADDR == cpci_pkg::TRIG_ADDR);
    assign lv = {PULSER_SHAPE_SEL, PULSER_POWER_ENABLE,
        CORE_FAST_RESET_DISABLE};
    chk_ctrl_value:
        assert property (wr_ctrl |=> lv == $past(PWDATA[2:0]))
        else $error("Control levels differ from written value.");
    chk_ctrl_static:
        assert property (!$stable(lv) |-> $past(wr_ctrl))
        else $error("Control level moved without a write.");
    chk_trig_value:
        assert property (wr_trig |=> PULSER_TRIGGER == $past(PWDATA[0]))
        else $error("Trigger level differs from written value.");
    chk_trig_static:
        assert property ($changed(PULSER_TRIGGER) |-> $past(wr_trig))
        else $error("Trigger moved without a write.");
    chk_accept_gate:
        assert property (EVENT_ACCEPT == (EVENT_IN && !ACQ_INHIBIT))
        else $error("Event accepted while inhibited.");
    chk_gate_cause:
        assert property (ACQ_INHIBIT |-> $past(CORE_INHIBIT, 2))
        else $error("Gate high without inhibit pin.");
    chk_gate_release:
        assert property (!CORE_INHIBIT |-> ##2 !ACQ_INHIBIT)
        else $error("Gate stays after inhibit pin fell.");
    chk_err_unmapped:
        assert property (PSEL && PENABLE && PADDR > 8'h18 |-> PSLVERR)
        else $error("Unmapped access not flagged.");
    chk_ready_access:
        assert property (PSEL && PENABLE |-> PREADY)
        else $error("Access phase not ready.");
    // Main scenarios reached.
    cov_ctrl: cover property (wr_ctrl);
    cov_gate: cover property ($rose(ACQ_INHIBIT));
    cov_err: cover property (PSLVERR);
endmodule : cpci_monitor

bind cpci_top cpci_monitor u_mon (.REF_CLK, .RST_B, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .CORE_FAST_RESET_DISABLE,
    .PULSER_POWER_ENABLE, .PULSER_SHAPE_SEL, .PULSER_TRIGGER,
    .CORE_INHIBIT, .EVENT_IN, .EVENT_ACCEPT, .ACQ_INHIBIT);

/* File: bench/cpci_preamp_model.sv */
// Behavioural model of the core preamplifier and its pulser.
`timescale 1ns/1ps

module cpci_preamp_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Cable levels from the digitiser
    input wire logic fast_reset_disable,
    input wire logic power_enable,
    input wire logic shape_sel,
    input wire logic trigger,
    // Saturation request from the bench
    input wire logic fire,
    input wire logic [7:0] fire_len,
    // Inhibit back, pulser state (0 rest, 1 up, 2 down)
    output logic inhibit,
    output logic [1:0] pulse_lvl
);
    logic [7:0] left_q; // Fast reset cycles still to run.
    logic trig_q; // Trigger level one cycle ago.
    // fast reset
    // A disabled fast reset ignores saturation entirely.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            left_q <= 8'h00;
        else if (fire && !fast_reset_disable && left_q == 8'h00)
            left_q <= fire_len;
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    assign inhibit = (left_q != 8'h00);
    // pulser edges
    // An unpowered pulser rests whatever the trigger does.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig_q <= 1'b0;
            pulse_lvl <= 2'h0;
        end
        else
        begin
            trig_q <= trigger;
            if (!power_enable)
                pulse_lvl <= 2'h0;
            else if (trigger && !trig_q)
                pulse_lvl <= 2'h1;
            else if (!trigger && trig_q)
                pulse_lvl <= shape_sel ? 2'h0 : 2'h2;
        end
    end
endmodule : cpci_preamp_model

/* File: bench/test_cpci_top.sv */
// Self-checking testbench for the core preamp control block.
`timescale 1ns/1ps

module test_cpci_top;
    logic ref_clk, rst_b, psel, penable, pwrite, event_in, fire, rd_err;
    logic [7:0] paddr, fire_len;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, frd, ppe, shp, trig, inh, ev_acc, acq, irq;
    logic [1:0] lvl;
    int errors, check_count;

    cpci_top dut (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CORE_FAST_RESET_DISABLE(frd), .PULSER_POWER_ENABLE(ppe),
        .PULSER_SHAPE_SEL(shp), .PULSER_TRIGGER(trig), .CORE_INHIBIT(inh),
        .EVENT_IN(event_in), .EVENT_ACCEPT(ev_acc), .ACQ_INHIBIT(acq),
        .IRQ(irq));
    cpci_preamp_model model (.clk(ref_clk), .rst_b(rst_b),
        .fast_reset_disable(frd), .power_enable(ppe), .shape_sel(shp),
        .trigger(trig), .fire(fire), .fire_len(fire_len), .inhibit(inh),
        .pulse_lvl(lvl));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report;
        $display("Checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // Let edges pass and step clear of them before looking.
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // One APB transfer; waits for ready under a bound.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        // Setup phase is launched right on a rising edge.
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 16)
        begin
            errors++;
            final_report;
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb

    // Bounded wait for the acquisition gate to reach a level.
    task wait_acq(input logic v);
        int n;
        n = 0;
        while (acq !== v && n < 40)
        begin
            tick(1);
            n++;
        end
        check("gate wait", n < 40, 1'b1);
        if (n >= 40)
            final_report;
    endtask : wait_acq

    task t_reset;
        check("levels", {trig, shp, ppe, frd}, 4'h0);
        apb(cpci_pkg::CTRL_ADDR, 1'b0, 32'h0);
        check("ctrl", rd, 32'h0);
        check("irq", irq, 1'b0);
        $display("Test reset done");
    endtask : t_reset

    task t_ctrl;
        for (int i = 0; i < 3; i++)
        begin
            apb(cpci_pkg::CTRL_ADDR, 1'b1, 32'h1 << i);
            check("levels", {shp, ppe, frd}, 3'h1 << i);
            apb(cpci_pkg::CTRL_ADDR, 1'b0, 32'h0);
            check("ctrl back", rd, 32'h1 << i);
        end
        $display("Test ctrl done");
    endtask : t_ctrl

    task t_pulser;
        for (int s = 0; s < 2; s++)
        begin
            apb(cpci_pkg::CTRL_ADDR, 1'b1, (s == 1) ? 32'h6 : 32'h2);
            apb(cpci_pkg::TRIG_ADDR, 1'b1, 32'h1);
            tick(2);
            check("rise", lvl, 2'h1);
            apb(cpci_pkg::TRIG_ADDR, 1'b1, 32'h0);
            tick(2);
            check("fall", lvl, (s == 1) ? 2'h0 : 2'h2);
        end
        apb(cpci_pkg::TRIG_ADDR, 1'b1, 32'h1);
        apb(cpci_pkg::CTRL_ADDR, 1'b1, 32'h0);
        tick(2);
        check("unpowered", lvl, 2'h0);
        apb(cpci_pkg::TRIG_ADDR, 1'b1, 32'h0);
        $display("Test pulser done");
    endtask : t_pulser

    // One-cycle saturation request, driven on rising edges.
    task kick;
        @(posedge ref_clk);
        fire_len <= 8'h05;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        #1;
    endtask : kick

    task t_inhibit;
        apb(cpci_pkg::CTRL_ADDR, 1'b1, 32'h8);
        apb(cpci_pkg::IRQM_ADDR, 1'b1, 32'h1);
        @(posedge ref_clk);
        event_in <= 1'b1;
        kick;
        wait_acq(1'b1);
        check("accept off", ev_acc, 1'b0);
        // Live status while the pulse is still being measured.
        apb(cpci_pkg::STAT_ADDR, 1'b0, 32'h0);
        check("live status", rd, 32'h7);
        wait_acq(1'b0);
        check("accept on", ev_acc, 1'b1);
        tick(4);
        apb(cpci_pkg::WID_ADDR, 1'b0, 32'h0);
        check("width", rd, 32'h5);
        apb(cpci_pkg::CNT_ADDR, 1'b0, 32'h0);
        check("count", rd, 32'h1);
        check("irq set", irq, 1'b1);
        apb(cpci_pkg::IRQS_ADDR, 1'b0, 32'h0);
        check("status", rd, 32'h5);
        apb(cpci_pkg::IRQS_ADDR, 1'b1, 32'h7);
        check("irq clear", irq, 1'b0);
        $display("Test inhibit done");
    endtask : t_inhibit

    task t_disable;
        apb(cpci_pkg::CTRL_ADDR, 1'b1, 32'h9);
        kick;
        tick(12);
        check("gate idle", acq, 1'b0);
        apb(cpci_pkg::CNT_ADDR, 1'b0, 32'h0);
        check("count", rd, 32'h1);
        apb(8'h1C, 1'b1, 32'h0);
        check("error", rd_err, 1'b1);
        apb(8'h1C, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        apb(cpci_pkg::CTRL_ADDR, 1'b0, 32'h0);
        check("ctrl kept", rd, 32'h9);
        $display("Test disable done");
    endtask : t_disable

    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        event_in = 1'b0;
        fire = 1'b0;
        fire_len = 8'h00;
        errors = 0;
        check_count = 0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(1);
        t_reset;
        t_ctrl;
        t_pulser;
        t_inhibit;
        t_disable;
        final_report;
    end
endmodule : test_cpci_top
